//--- design/sbal_map.vh
// Constants for the skip and bit-addressing sequencer
// Assumes the core decodes opcodes into the class codes defined here
`ifndef SBAL_MAP_VH
`define SBAL_MAP_VH
// Instruction classes presented by the decoder
`define SBAL_CLS_OTHER 5'h00
`define SBAL_CLS_LD_A_IMM 5'h01
`define SBAL_CLS_LD_EA_IMM 5'h02
`define SBAL_CLS_LD_HL_IMM 5'h03
`define SBAL_CLS_REF 5'h04
`define SBAL_CLS_XCH_INC 5'h05
`define SBAL_CLS_XCH_DEC 5'h06
`define SBAL_CLS_LD_INC 5'h07
`define SBAL_CLS_LD_DEC 5'h08
`define SBAL_CLS_INC_SKIP 5'h09
`define SBAL_CLS_DEC_SKIP 5'h0a
`define SBAL_CLS_ADD_SKIP 5'h0b
`define SBAL_CLS_SUB_SKIP 5'h0c
`define SBAL_CLS_BIT_TRUE 5'h0d
`define SBAL_CLS_BIT_FALSE 5'h0e
`define SBAL_CLS_CMP_EQ 5'h0f
`define SBAL_CLS_ADC_HL 5'h10
`define SBAL_CLS_SBC_HL 5'h11
`define SBAL_CLS_ADC 5'h12
`define SBAL_CLS_SBC 5'h13
`define SBAL_CLS_SCF 5'h14
`define SBAL_CLS_RCF 5'h15
`define SBAL_CLS_CCF 5'h16
`define SBAL_CLS_RRC 5'h17
`define SBAL_CLS_CBIT 5'h18
`define SBAL_CLS_IRET 5'h19
`define SBAL_CLS_ADS_A_IMM 5'h1a
// Bit addressing modes
`define SBAL_MODE_SHORT 2'h0
`define SBAL_MODE_LIDX 2'h1
`define SBAL_MODE_HDIR 2'h2
// Address windows
`define SBAL_SHORT_LO1 12'hfb0
`define SBAL_SHORT_HI1 12'hfbf
`define SBAL_SHORT_LO2 12'hff1
`define SBAL_SHORT_HI2 12'hff9
`define SBAL_LIDX_LO 12'hfc0
`define SBAL_LIDX_HI 12'hff9
`define SBAL_REF_AREA_LO 16'h0020
`define SBAL_REF_AREA_HI 16'h007f
// Redundancy kinds
`define SBAL_RED_NONE 2'h0
`define SBAL_RED_ACC 2'h1
`define SBAL_RED_PTR 2'h2
`endif

//--- design/sbal_bit_addr.v
// Bit address former for the three bit-addressing modes
// Assumes operands are stable during the instruction that uses them
`timescale 1ns/10ps
`include "sbal_map.vh"
module sbal_bit_addr (
  input wire [1:0] mode,
  input wire [7:0] short_addr,
  input wire [3:0] l_reg,
  input wire [5:0] lidx_base,
  input wire [3:0] h_reg,
  input wire [3:0] direct_lo,
  input wire mem_bank_en,
  input wire [3:0] sel_bank,
  output reg [11:0] bit_addr,
  output reg addr_ok
);
  reg [11:0] word_addr;
  // Forms the word address and checks its range per mode
  always @* begin
    word_addr = 12'h000;
    addr_ok = 1'b0;
    case (mode)
      `SBAL_MODE_SHORT: begin
        word_addr = {4'hf, short_addr};
        addr_ok = (word_addr >= `SBAL_SHORT_LO1 &&
                   word_addr <= `SBAL_SHORT_HI1) ||
                  (word_addr >= `SBAL_SHORT_LO2 &&
                   word_addr <= `SBAL_SHORT_HI2); // RL5
      end
      `SBAL_MODE_LIDX: begin
        // Upper L bits pick the word, low two bits pick the bit
        word_addr = {6'h3f, lidx_base + {4'h0, l_reg[3:2]}};
        addr_ok = word_addr >= `SBAL_LIDX_LO &&
                  word_addr <= `SBAL_LIDX_HI; // RL5
      end
      `SBAL_MODE_HDIR: begin
        // Bank 15 when bank enable is clear, else the selected bank
        word_addr = {mem_bank_en ? sel_bank : 4'hf, h_reg, direct_lo};
        addr_ok = 1'b1; // RL6
      end
      default: begin
        word_addr = 12'h000;
        addr_ok = 1'b0;
      end
    endcase
    bit_addr = word_addr;
  end
endmodule // sbal_bit_addr

//--- design/sbal_seq.v
// Skip, redundancy and carry sequencing for a 4-bit core
// Assumes decoder gives class per instruction with an instr_done strobe
`timescale 1ns/10ps
`include "sbal_map.vh"
// What this block does
// RL1: A reference to a table entry executes the stored instruction in place.
// RL2: Consecutive same-kind immediate loads: first runs, the rest become no-ops.
// RL3: Redundancy before a reference is cancelled; referenced instruction runs.
// RL4: Instruction after a reference, redundant to it, is skipped.
// RL5: Short bit mode FB0-FBF, FF1-FF9; L-indexed mode FC0-FF9.
// RL6: H-plus-direct mode reaches all bit locations of the chosen bank.
// RL7: Increment/decrement style skips raise skip on overflow or borrow.
// RL8: Bit tests and compare raise skip on condition; carry untouched.
// RL9: Carry-changing instructions listed never raise skip.
// RL10: Add-immediate-skip after ADC/SBC on HL has its own skip cut.
// RL11: ADC overflow or SBC no-borrow skips the following add-immediate.
// RL12: Skip is a pending flag that nops the next instruction, then clears.
module sbal_seq (
  input wire sys_clk,
  input wire resetn,
  input wire instr_done,
  input wire [4:0] instr_class,
  input wire ref_fetch,
  input wire [4:0] ref_class,
  input wire [15:0] ref_addr,
  input wire overflow,
  input wire borrow,
  input wire cond_met,
  input wire carry_in,
  input wire carry_val,
  input wire [1:0] bit_mode,
  input wire [7:0] short_addr,
  input wire [3:0] l_reg,
  input wire [5:0] lidx_base,
  input wire [3:0] h_reg,
  input wire [3:0] direct_lo,
  input wire mem_bank_en,
  input wire [3:0] sel_bank,
  output reg exec_nop_q,
  output reg skip_pending_q,
  output reg ref_exec_q,
  output reg carry_q,
  output reg carry_we_q,
  output reg [11:0] bit_addr_q,
  output reg bit_addr_ok_q
);
  reg [1:0] last_red_q;
  reg [1:0] last_red_d;
  reg chain_q;
  reg chain_d;
  reg skip_d;
  reg carry_d;
  reg carry_we_d;
  reg ref_exec_d;
  reg [1:0] cur_red;
  reg red_hit;
  reg [4:0] eff_class;
  reg is_ref_table;
  wire [11:0] ba;
  wire ba_ok;

  // Redundancy kind of a class
  function [1:0] red_kind;
    input [4:0] c;
    begin
      case (c)
        `SBAL_CLS_LD_A_IMM: red_kind = `SBAL_RED_ACC;
        `SBAL_CLS_LD_EA_IMM: red_kind = `SBAL_RED_ACC;
        `SBAL_CLS_LD_HL_IMM: red_kind = `SBAL_RED_PTR;
        default: red_kind = `SBAL_RED_NONE;
      endcase
    end
  endfunction

  // Bit address former
  sbal_bit_addr u_bit_addr (
    .mode(bit_mode),
    .short_addr(short_addr),
    .l_reg(l_reg),
    .lidx_base(lidx_base),
    .h_reg(h_reg),
    .direct_lo(direct_lo),
    .mem_bank_en(mem_bank_en),
    .sel_bank(sel_bank),
    .bit_addr(ba),
    .addr_ok(ba_ok)
  );

  // Next-state decision for each completing instruction
  always @* begin
    is_ref_table = instr_class == `SBAL_CLS_REF && ref_fetch &&
                   ref_addr >= `SBAL_REF_AREA_LO &&
                   ref_addr <= `SBAL_REF_AREA_HI;
    // Referenced entry runs in place of the reference
    eff_class = is_ref_table ? ref_class : instr_class; // RL1
    cur_red = red_kind(eff_class);
    // Same-kind load right after another, outside a skip or reference
    red_hit = !skip_pending_q && !is_ref_table &&
              cur_red != `SBAL_RED_NONE && cur_red == last_red_q; // RL2
    skip_d = 1'b0;
    chain_d = 1'b0;
    carry_d = carry_q;
    carry_we_d = 1'b0;
    ref_exec_d = is_ref_table && !skip_pending_q; // RL1
    last_red_d = last_red_q;
    if (skip_pending_q) begin
      // Nopped instruction consumes the pending skip
      last_red_d = `SBAL_RED_NONE; // RL12
    end else if (is_ref_table) begin
      // Prior redundancy is ignored for the referenced one
      last_red_d = cur_red; // RL3 RL4
    end else if (cur_red != `SBAL_RED_NONE &&
                 cur_red == last_red_q) begin
      last_red_d = cur_red; // RL2
    end else begin
      last_red_d = cur_red;
      case (eff_class)
        `SBAL_CLS_XCH_INC, `SBAL_CLS_LD_INC, `SBAL_CLS_INC_SKIP,
        `SBAL_CLS_ADD_SKIP:
          skip_d = overflow; // RL7
        `SBAL_CLS_XCH_DEC, `SBAL_CLS_LD_DEC, `SBAL_CLS_DEC_SKIP,
        `SBAL_CLS_SUB_SKIP:
          skip_d = borrow; // RL7
        `SBAL_CLS_ADS_A_IMM:
          skip_d = chain_q ? 1'b0 : overflow; // RL10
        `SBAL_CLS_BIT_TRUE, `SBAL_CLS_BIT_FALSE, `SBAL_CLS_CMP_EQ:
          skip_d = cond_met; // RL8
        `SBAL_CLS_ADC_HL: begin
          chain_d = 1'b1;
          carry_d = carry_val;
          carry_we_d = 1'b1;
          skip_d = overflow; // RL11
        end
        `SBAL_CLS_SBC_HL: begin
          chain_d = 1'b1;
          carry_d = carry_val;
          carry_we_d = 1'b1;
          skip_d = ~borrow; // RL11
        end
        `SBAL_CLS_ADC, `SBAL_CLS_SBC, `SBAL_CLS_RRC, `SBAL_CLS_CBIT,
        `SBAL_CLS_IRET: begin
          carry_d = carry_val;
          carry_we_d = 1'b1; // RL9
        end
        `SBAL_CLS_SCF: begin
          carry_d = 1'b1;
          carry_we_d = 1'b1; // RL9
        end
        `SBAL_CLS_RCF: begin
          carry_d = 1'b0;
          carry_we_d = 1'b1; // RL9
        end
        `SBAL_CLS_CCF: begin
          carry_d = ~carry_q;
          carry_we_d = 1'b1; // RL9
        end
        default: skip_d = 1'b0;
      endcase
    end
  end

  // State registers; bit address and carry write-enable update every clock, the rest when an instruction completes
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      last_red_q <= 2'h0;
      chain_q <= 1'b0;
      skip_pending_q <= 1'b0;
      exec_nop_q <= 1'b0;
      ref_exec_q <= 1'b0;
      carry_q <= 1'b0;
      carry_we_q <= 1'b0;
      bit_addr_q <= 12'h000;
      bit_addr_ok_q <= 1'b0;
    end else begin
      bit_addr_q <= ba;
      bit_addr_ok_q <= ba_ok;
      carry_we_q <= instr_done & carry_we_d;
      if (instr_done) begin
        last_red_q <= last_red_d;
        chain_q <= chain_d;
        skip_pending_q <= skip_d; // RL12
        carry_q <= carry_d;
        ref_exec_q <= ref_exec_d;
        // Next instruction runs as nop if skipped or redundant
        exec_nop_q <= skip_d || red_hit; // RL2 RL4
      end
    end
  end
endmodule // sbal_seq

//--- test/sbal_seq_asserts.sv
// Checker for skip, chain and carry sequencing of sbal_seq
// Assumes it is bound to sbal_seq and sees only its ports
`timescale 1ns/10ps
`include "sbal_map.vh"
module sbal_seq_asserts (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic instr_done,
  input wire logic [4:0] instr_class,
  input wire logic overflow,
  input wire logic borrow,
  input wire logic cond_met,
  input wire logic carry_val,
  input wire logic [1:0] bit_mode,
  input wire logic exec_nop_q,
  input wire logic skip_pending_q,
  input wire logic carry_q,
  input wire logic carry_we_q,
  input wire logic [11:0] bit_addr_q,
  input wire logic bit_addr_ok_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // Instruction that really executes, not nopped
  wire logic run = instr_done && !exec_nop_q;
  wire logic [4:0] k = instr_class;
  wire logic grp = k >= `SBAL_CLS_XCH_INC && k <= `SBAL_CLS_SUB_SKIP;
  // Skip raising, carry kept, skip cleared
  ovf_skip_a: assert property (
    run && grp && overflow && borrow |=> skip_pending_q)
    else $error("overflow skip missing");
  keep_carry_a: assert property (
    instr_done && k >= `SBAL_CLS_XCH_INC && k <= `SBAL_CLS_CMP_EQ
    |=> $stable(carry_q) && !carry_we_q) else $error("carry changed");
  cond_skip_a: assert property (
    run && k == `SBAL_CLS_BIT_TRUE && cond_met |=> skip_pending_q)
    else $error("bit test skip missing");
  carry_set_a: assert property (
    run && (k == `SBAL_CLS_ADC || k == `SBAL_CLS_SBC ||
    k >= `SBAL_CLS_RRC && k <= `SBAL_CLS_IRET)
    |=> carry_we_q && carry_q == $past(carry_val) && !skip_pending_q)
    else $error("carry update wrong");
  skip_clear_a: assert property (
    instr_done && skip_pending_q |=> !skip_pending_q)
    else $error("skip held too long");
  chain_skip_a: assert property (
    run && (k == `SBAL_CLS_ADC_HL && overflow ||
    k == `SBAL_CLS_SBC_HL && !borrow) |=> skip_pending_q)
    else $error("chain skip missing");
  chain_cut_a: assert property (
    run && (k == `SBAL_CLS_ADC_HL && !overflow ||
    k == `SBAL_CLS_SBC_HL && borrow) ##1
    instr_done && k == `SBAL_CLS_ADS_A_IMM |=> !skip_pending_q)
    else $error("chained add skipped");
  short_range_a: assert property (
    bit_addr_ok_q && $past(bit_mode) == `SBAL_MODE_SHORT |->
    bit_addr_q inside {[`SBAL_SHORT_LO1:`SBAL_SHORT_HI1],
    [`SBAL_SHORT_LO2:`SBAL_SHORT_HI2]}) else $error("short bit out");
  lidx_range_a: assert property (
    bit_addr_ok_q && $past(bit_mode) == `SBAL_MODE_LIDX |->
    bit_addr_q inside {[`SBAL_LIDX_LO:`SBAL_LIDX_HI]})
    else $error("indexed bit out");
  // Main scenarios seen
  cover property (instr_done && skip_pending_q);
  cover property (carry_we_q);
  cover property (bit_addr_ok_q);
endmodule // sbal_seq_asserts
bind sbal_seq sbal_seq_asserts chk_u (.*);

//--- test/test_skip_and_bit_addressing_logic.sv
// Self-checking bench for sbal_seq, directed then random
// Assumes sbal_map.vh class codes and a 100 ns machine clock
`timescale 1ns/10ps
`include "sbal_map.vh"
`define SB_EQ(a, b) begin compares++; if ((a) !== (b)) begin \
  failures++; $display("wrong value at %0t: output mismatch", $time); end end
module test_skip_and_bit_addressing_logic;
  logic sys_clk = 0, resetn = 0, instr_done = 0, ref_fetch = 0;
  logic overflow = 0, borrow = 0, cond_met = 0, carry_in = 0;
  logic carry_val = 0, mem_bank_en = 0;
  logic [4:0] instr_class = 0, ref_class = 0;
  logic [15:0] ref_addr = 0;
  logic [1:0] bit_mode = 0;
  logic [7:0] short_addr = 0;
  logic [3:0] l_reg = 0, h_reg = 0, direct_lo = 0, sel_bank = 0;
  logic [5:0] lidx_base = 0;
  logic exec_nop_q, skip_pending_q, ref_exec_q, carry_q, carry_we_q;
  logic bit_addr_ok_q;
  logic [11:0] bit_addr_q;
  int failures = 0, compares = 0, cycles = 0, i, j;
  int seed = 32'hc149_2128;
  logic [31:0] r;
  logic c_exp = 0;
  // Chain table: class, flags, expected skip
  logic [6:0] ch [0:9] = '{{`SBAL_CLS_ADC_HL, 2'b11}, {`SBAL_CLS_ADS_A_IMM,
    2'b00}, {`SBAL_CLS_SBC_HL, 2'b01}, {`SBAL_CLS_ADS_A_IMM, 2'b00},
    {`SBAL_CLS_ADC_HL, 2'b00}, {`SBAL_CLS_ADS_A_IMM, 2'b10},
    {`SBAL_CLS_SBC_HL, 2'b10}, {`SBAL_CLS_ADS_A_IMM, 2'b10},
    {`SBAL_CLS_ADS_A_IMM, 2'b11}, {`SBAL_CLS_OTHER, 2'b00}};
  sbal_seq dut_u (.*);
  // Machine clock and cycle ceiling
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      report_and_stop();
    end
  end
  // Flags all equal: skip classes raise skip exactly when set
  function automatic logic f_sk(input logic f);
    return f;
  endfunction
  // Carry after a carry-changing class, p is the carry before
  function automatic logic f_cy(input logic [4:0] k, input logic v, p);
    case (k)
      `SBAL_CLS_SCF: return 1'b1;
      `SBAL_CLS_RCF: return 1'b0;
      `SBAL_CLS_CCF: return ~p;
      default: return v;
    endcase
  endfunction
  // Expected {in range, word address} for a bit mode and its operands
  function automatic logic [12:0] f_ba(input logic [1:0] m,
    input logic [7:0] s, input logic [3:0] l, input logic [5:0] b,
    input logic [3:0] h, d, input logic e, input logic [3:0] bk);
    logic [11:0] a;
    logic ok;
    a = {e ? bk : 4'hf, h, d};
    ok = 1'b1;
    if (m == `SBAL_MODE_SHORT) begin
      a = {4'hf, s};
      ok = (a >= `SBAL_SHORT_LO1 && a <= `SBAL_SHORT_HI1) ||
           (a >= `SBAL_SHORT_LO2 && a <= `SBAL_SHORT_HI2);
    end else if (m == `SBAL_MODE_LIDX) begin
      a = `SBAL_LIDX_LO + {6'h00, 6'(b + l[3:2])};
      ok = a <= `SBAL_LIDX_HI;
    end
    return {ok, a};
  endfunction
  // One completing instruction with all result flags equal to f
  task step(input logic [4:0] k, input logic f);
    instr_done <= 1;
    instr_class <= k;
    {overflow, borrow, cond_met, carry_val} <= {4{f}};
    @(posedge sys_clk) #1;
  endtask
  task report_and_stop;
    if (failures == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Directed corner cases, then random traffic
  initial begin
    repeat (3) @(posedge sys_clk);
    resetn <= 1;
    @(posedge sys_clk) #1;
    for (i = 5; i <= 15; i++) begin
      step(5'(i), 1);
      `SB_EQ(skip_pending_q, f_sk(1))
      `SB_EQ(carry_we_q, 1'b0)
      step(`SBAL_CLS_OTHER, 0);
      `SB_EQ(skip_pending_q, 1'b0)
      step(5'(i), 0);
      `SB_EQ(skip_pending_q, f_sk(0))
    end
    for (i = 18; i <= 25; i++)
      for (j = 0; j < 2; j++) begin
        step(5'(i), j[0]);
        c_exp = f_cy(5'(i), j[0], c_exp);
        `SB_EQ({carry_q, skip_pending_q, carry_we_q}, {c_exp, 2'b01})
      end
    for (i = 0; i < 10; i++) begin
      step(ch[i][6:2], ch[i][1]);
      `SB_EQ(skip_pending_q, ch[i][0])
    end
    step(`SBAL_CLS_LD_A_IMM, 0);
    `SB_EQ(exec_nop_q, 1'b0)
    step(`SBAL_CLS_LD_EA_IMM, 0);
    `SB_EQ(exec_nop_q, 1'b1)
    ref_fetch <= 1;
    ref_addr <= `SBAL_REF_AREA_LO;
    ref_class <= `SBAL_CLS_LD_EA_IMM;
    step(`SBAL_CLS_REF, 0);
    `SB_EQ({ref_exec_q, exec_nop_q}, 2'b10)
    step(`SBAL_CLS_LD_EA_IMM, 0);
    `SB_EQ({ref_exec_q, exec_nop_q}, 2'b01)
    repeat (600) begin
      r = $random(seed);
      {ref_fetch, mem_bank_en, carry_in} <= r[2:0];
      {overflow, borrow, cond_met, carry_val} <= r[6:3];
      bit_mode <= r[8] ? `SBAL_MODE_HDIR : {1'b0, r[7]};
      {short_addr, l_reg, lidx_base, h_reg} <= r[30:9];
      instr_done <= r[31];
      r = $random(seed);
      {direct_lo, sel_bank, ref_addr} <= r[23:0];
      instr_class <= 5'(r[31:27] % 27);
      ref_class <= 5'(r[28:24] % 27);
      @(posedge sys_clk) #1;
      `SB_EQ({bit_addr_ok_q, bit_addr_q}, f_ba(bit_mode, short_addr, l_reg,
        lidx_base, h_reg, direct_lo, mem_bank_en, sel_bank))
    end
    report_and_stop();
  end
endmodule // test_skip_and_bit_addressing_logic
